//--- verilog/tof_timeout_pkg.sv
// package: register map, field layout and timing constants of the timeout block
`default_nettype none
package tof_timeout_pkg;
   // -----------------------------------------------------------------
   // register byte offsets
   // -----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_WAVE = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MASK = 8'h0C;
   localparam logic [7:0] OFS_STATE = 8'h10;
   localparam logic [7:0] OFS_TOF_RES = 8'h20;
   // temperature block sits clear of the six-word hit block at 0x20..0x37
   localparam logic [7:0] OFS_TEMP_RES = 8'h40;
   // -----------------------------------------------------------------
   // field positions and values
   // -----------------------------------------------------------------
   localparam int TSEL_LSB = 0;
   localparam int INTEN_BIT = 3;
   localparam int STAT_TO_BIT = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_OPEN_BIT = 2;
   localparam int STAT_W = 3;
   localparam int HIT1_LSB = 8;
   localparam logic [15:0] WAVE_RESET = 16'h0000;
   localparam logic [15:0] WAVE_MASK = 16'h3F3F;
   localparam logic [15:0] INVALID_RESULT = 16'hFFFF;
   localparam logic [5:0] MIN_HIT2_WAVE = 6'h04;
   localparam logic [2:0] TSEL_MAX = 3'h4;
   // -----------------------------------------------------------------
   // timing: base window 128 us at 200 MHz, doubled per code step
   // -----------------------------------------------------------------
   localparam int CLK_MHZ = 200;
   localparam int BASE_WINDOW_US = 128;
   localparam int BASE_WINDOW_CYC = BASE_WINDOW_US * CLK_MHZ;
   localparam int NUM_HITS = 6;
   localparam int NUM_TEMP = 4;
   typedef enum logic [1:0]
   {
      ST_IDLE = 2'b00,
      ST_TOF = 2'b01,
      ST_TEMP = 2'b10
   } meas_state_t;
   // measurement start request from the sequencer
   typedef struct packed
   {
      logic tof_start;
      logic temp_start;
      logic [1:0] temp_index;
   } meas_req_t;
   // arrival events from the time-to-digital core
   typedef struct packed
   {
      logic [NUM_HITS-1:0] hit;
      logic [15:0] hit_value;
      logic temp_done;
      logic [15:0] temp_value;
   } meas_evt_t;
endpackage
`default_nettype wire

//--- verilog/tof_timeout.sv
// timeout supervisor, wave select register and result store behind apb
//
// The APB slave port and the register addresses were chosen for this implementation.
`default_nettype none

module tof_timeout
   import tof_timeout_pkg::*;
#(
   parameter int BASE_CYCLES = BASE_WINDOW_CYC
)
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire meas_req_t meas_req,
   input wire meas_evt_t meas_evt,
   output logic [5:0] first_stop_wave,
   output logic [5:0] second_stop_wave,
   output logic meas_abort,
   output logic irq
);
   // window counter wide enough for the base shifted by the longest code
   localparam int TW = $clog2(BASE_CYCLES) + 5;
   // elaboration check: a zero base would wrap the limit window_cyc - 1 to all ones instead of an empty window
   if (BASE_CYCLES < 1)
   begin : g_bad_base
      $error("BASE_CYCLES must be at least one");
   end
   // width follows the base, so nothing else is refused

   // -----------------------------------------------------------------
   // bus decode
   // -----------------------------------------------------------------
   logic wr_en;
   logic rd_en;
   logic hit_ok;
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && penable && !pwrite;
   assign pready = 1'b1;

   logic [3:0] ctrl_r;
   logic [15:0] stop_wave_select_r;
   logic [STAT_W-1:0] status_r;
   logic [STAT_W-1:0] mask_r;
   meas_state_t state_r;
   logic [TW-1:0] count_r;
   logic [NUM_HITS-1:0] hits_seen_r;
   logic [15:0] tof_res_r [NUM_HITS];
   logic [NUM_HITS-1:0] tof_valid_r;
   logic [15:0] temp_res_r [NUM_TEMP];
   logic [NUM_TEMP-1:0] temp_valid_r;
   logic [1:0] temp_idx_r;
   logic timeout_evt;
   logic done_evt;
   logic [TW-1:0] window_cyc;

   // control: timeout select and interrupt enable; code write lands whole
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         ctrl_r <= 4'h0;
      else if (wr_en && paddr == OFS_CTRL && pstrb[0])
         ctrl_r <= pwdata[3:0];
   end

   // wave select register, reserved bits forced to zero
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         stop_wave_select_r <= WAVE_RESET;
      else if (wr_en && paddr == OFS_WAVE)
      begin
         if (pstrb[0])
            stop_wave_select_r[7:0] <= pwdata[7:0] & WAVE_MASK[7:0];
         if (pstrb[1])
            stop_wave_select_r[15:8] <= pwdata[15:8] & WAVE_MASK[15:8];
      end
   end

   // second hit never earlier than wave four; ordering is left to the host
   assign first_stop_wave = stop_wave_select_r[HIT1_LSB +: 6];
   assign second_stop_wave = (stop_wave_select_r[5:0] <= MIN_HIT2_WAVE) ?
      MIN_HIT2_WAVE : stop_wave_select_r[5:0];

   // -----------------------------------------------------------------
   // timeout window
   // -----------------------------------------------------------------
   // reserved codes clamp to the longest window rather than wrap
   always_comb
   begin
      if (ctrl_r[2:0] > TSEL_MAX)
         window_cyc = TW'(BASE_CYCLES) << TSEL_MAX;
      else
         window_cyc = TW'(BASE_CYCLES) << ctrl_r[2:0];
   end

   // sequencer: count while waiting for hits or temperature reading
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         state_r <= ST_IDLE;
         count_r <= '0;
         hits_seen_r <= '0;
         temp_idx_r <= 2'b00;
      end
      else
      begin
         unique case (state_r)
            ST_IDLE:
            begin
               count_r <= '0;
               hits_seen_r <= '0;
               if (meas_req.tof_start)
                  state_r <= ST_TOF;
               else if (meas_req.temp_start)
               begin
                  state_r <= ST_TEMP;
                  temp_idx_r <= meas_req.temp_index;
               end
            end
            ST_TOF:
            begin
               count_r <= count_r + 1'b1;
               hits_seen_r <= hits_seen_r | meas_evt.hit;
               if (timeout_evt || done_evt)
                  state_r <= ST_IDLE;
            end
            ST_TEMP:
            begin
               count_r <= count_r + 1'b1;
               if (timeout_evt || done_evt)
                  state_r <= ST_IDLE;
            end
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   assign hit_ok = &(hits_seen_r | meas_evt.hit);
   assign done_evt = (state_r == ST_TOF) ? hit_ok :
      (state_r == ST_TEMP) ? meas_evt.temp_done : 1'b0;
   // a missing hit or temperature result at window end aborts the measurement
   assign timeout_evt = (state_r != ST_IDLE) && !done_evt
      && (count_r >= window_cyc - 1'b1);

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         meas_abort <= 1'b0;
      else
         meas_abort <= timeout_evt;
   end

   // -----------------------------------------------------------------
   // result store
   // -----------------------------------------------------------------
   // hits captured as they come; a new tof start invalidates old hit results
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         tof_valid_r <= '0;
      else if (state_r == ST_IDLE && meas_req.tof_start)
         tof_valid_r <= '0;
      else if (state_r == ST_TOF)
         tof_valid_r <= tof_valid_r | meas_evt.hit;
   end

   for (genvar g = 0; g < NUM_HITS; g++)
   begin : g_hit
      always_ff @(posedge sys_clk)
      begin
         if (!reset_n)
            tof_res_r[g] <= INVALID_RESULT;
         else if (state_r == ST_TOF && meas_evt.hit[g])
            tof_res_r[g] <= meas_evt.hit_value;
      end
   end

   // overrun forces all ones to flag an open probe
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         temp_valid_r <= '0;
      else if (state_r == ST_TEMP && (timeout_evt || done_evt))
         temp_valid_r[temp_idx_r] <= done_evt;
   end

   for (genvar t = 0; t < NUM_TEMP; t++)
   begin : g_temp
      always_ff @(posedge sys_clk)
      begin
         if (!reset_n)
            temp_res_r[t] <= INVALID_RESULT;
         else if (state_r == ST_TEMP && temp_idx_r == 2'(t))
         begin
            if (done_evt)
               temp_res_r[t] <= meas_evt.temp_value;
            else if (timeout_evt)
               temp_res_r[t] <= INVALID_RESULT;
         end
      end
   end

   // -----------------------------------------------------------------
   // interrupt status, mask and pin
   // -----------------------------------------------------------------
   // set wins over a simultaneous write-one-to-clear
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         status_r <= '0;
      else
      begin
         for (int i = 0; i < STAT_W; i++)
         begin
            if (wr_en && paddr == OFS_STATUS && pstrb[0] && pwdata[i])
               status_r[i] <= 1'b0;
         end
         if (timeout_evt)
            status_r[STAT_TO_BIT] <= 1'b1;
         if (done_evt)
            status_r[STAT_DONE_BIT] <= 1'b1;
         if (timeout_evt && state_r == ST_TEMP)
            status_r[STAT_OPEN_BIT] <= 1'b1;
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         mask_r <= '0;
      else if (wr_en && paddr == OFS_MASK && pstrb[0])
         mask_r <= pwdata[STAT_W-1:0];
   end

   // pin gated by global enable and per-bit mask
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
         irq <= 1'b0;
      else
         irq <= ctrl_r[INTEN_BIT] && |(status_r & mask_r);
   end

   // -----------------------------------------------------------------
   // read mux
   // -----------------------------------------------------------------
   // invalid results always read back as all ones
   always_ff @(posedge sys_clk)
   begin
      if (!reset_n)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end
      else if (psel && !penable)
      begin
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
         if (paddr == OFS_CTRL)
            prdata[3:0] <= ctrl_r;
         else if (paddr == OFS_WAVE)
            prdata[15:0] <= stop_wave_select_r;
         else if (paddr == OFS_STATUS)
            prdata[STAT_W-1:0] <= status_r;
         else if (paddr == OFS_MASK)
            prdata[STAT_W-1:0] <= mask_r;
         else if (paddr == OFS_STATE)
            prdata[1:0] <= state_r;
         else if (paddr >= OFS_TOF_RES && paddr < OFS_TOF_RES + 8'(4 * NUM_HITS)
                  && paddr[1:0] == 2'b00)
            prdata[15:0] <= tof_valid_r[3'(paddr[4:2])] ?
               tof_res_r[3'(paddr[4:2])] : INVALID_RESULT;
         else if (paddr >= OFS_TEMP_RES && paddr < OFS_TEMP_RES + 8'(4 * NUM_TEMP)
                  && paddr[1:0] == 2'b00)
            prdata[15:0] <= temp_valid_r[paddr[3:2]] ?
               temp_res_r[paddr[3:2]] : INVALID_RESULT;
         else
            pslverr <= 1'b1; // unmapped address
      end
   end
   logic unused_rd;
   assign unused_rd = rd_en;
endmodule // tof_timeout
`default_nettype wire

//--- tb/tof_timeout_props.sv
// port assertions for the timeout block
`default_nettype none
module tof_timeout_props
   import tof_timeout_pkg::*;
(
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   input wire logic pslverr,
   input wire logic [5:0] first_stop_wave,
   input wire logic [5:0] second_stop_wave,
   input wire logic meas_abort,
   input wire logic irq
);
   default clocking @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);
   // full-word wave write; a_wave_hold treats a partial-strobe write as no write
   logic ww;
   assign ww = psel && penable && pwrite && paddr == OFS_WAVE && pstrb == 4'hF;
   a_wave_floor: assert property (second_stop_wave >= MIN_HIT2_WAVE)
      else $error("wave floor");
   a_wave_clamp: assert property (
      ww && pwdata[5:0] < 6'h04 |=> second_stop_wave == MIN_HIT2_WAVE)
      else $error("wave clamp");
   a_wave_pass: assert property (
      ww && pwdata[5:0] >= 6'h04 |=> second_stop_wave == $past(pwdata[5:0]))
      else $error("wave pass");
   a_first_wave: assert property (ww |=> first_stop_wave == $past(pwdata[13:8]))
      else $error("first wave");
   a_wave_hold: assert property (!ww |=> $stable(first_stop_wave))
      else $error("wave hold");
   a_abort_pulse: assert property (meas_abort |=> !meas_abort)
      else $error("abort pulse");
   a_reset_vals: assert property ($rose(reset_n) |->
      first_stop_wave == 6'h00 && second_stop_wave == MIN_HIT2_WAVE && !irq)
      else $error("reset values");
   a_unmapped_err: assert property (psel && !penable && paddr == 8'h14 |=> pslverr)
      else $error("unmapped");
   c_abort: cover property (meas_abort);
   c_irq: cover property ($rose(irq));
   c_err: cover property (pslverr);
endmodule // tof_timeout_props
`default_nettype wire

//--- tb/tdc_model.sv
// behavioural time-to-digital core: stop hits and temperature results
`default_nettype none
module tdc_model
   import tof_timeout_pkg::*;
(
   input wire logic sys_clk,
   output var meas_evt_t meas_evt
);
   timeunit 1ns;
   timeprecision 1ps;
   initial meas_evt = '0;
   // released data lines flip so a stale value never matches
   task automatic tof(input int n, input int gap);
      for (int i = 0; i < n; i++)
      begin
         repeat (gap) @(posedge sys_clk);
         meas_evt.hit <= 6'h01 << i;
         meas_evt.hit_value <= 16'h1000 + 16'(i);
         @(posedge sys_clk);
         meas_evt.hit <= '0;
         meas_evt.hit_value <= ~(16'h1000 + 16'(i));
      end
   endtask
   task automatic temp(input int gap, input logic [15:0] v);
      repeat (gap) @(posedge sys_clk);
      meas_evt.temp_done <= 1'b1;
      meas_evt.temp_value <= v;
      @(posedge sys_clk);
      meas_evt.temp_done <= 1'b0;
      meas_evt.temp_value <= ~v;
   endtask
endmodule // tdc_model
`default_nettype wire

//--- tb/tb_tof_timeout.sv
// self-checking bench for the timeout block
`default_nettype none
module tb_tof_timeout;
   import tof_timeout_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BASE = 4;
   logic sys_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, er;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, meas_abort, irq;
   logic [5:0] first_stop_wave, second_stop_wave;
   meas_req_t meas_req = '0;
   meas_evt_t meas_evt;
   int miscompares = 0, num_checks = 0, n;
   tof_timeout #(.BASE_CYCLES(BASE)) i_tof_timeout (.sys_clk, .reset_n, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .meas_req, .meas_evt, .first_stop_wave, .second_stop_wave, .meas_abort, .irq);
   tdc_model i_tdc_model (.sys_clk, .meas_evt);
   initial forever #2.5 sys_clk = ~sys_clk;
   // apb master: request held until pready is seen
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         miscompares++;
         $display("[ERR] %s exp %h got %h", s, e, g);
      end
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string s);
      xfer(1'b0, a, 32'h0);
      chk(s, e, rd);
   endtask
   // start pulse, then count cycles until abort or limit
   task automatic run(input logic t, input logic [1:0] ix, input int lim);
      @(posedge sys_clk);
      meas_req <= '{t, !t, ix};
      @(posedge sys_clk);
      meas_req <= '0;
      n = 1;
      while (meas_abort !== 1'b1 && n < lim)
      begin
         @(negedge sys_clk);
         n++;
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d miscompares %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog sized well above the whole sequence
   initial
   begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      tally_and_finish;
   end
   initial
   begin
      repeat (4) @(posedge sys_clk);
      reset_n <= 1'b1;
      rchk(OFS_WAVE, 32'h0, "wave");
      rchk(OFS_STATE, 32'h0, "state idle");
      rchk(OFS_TOF_RES, 32'hFFFF, "tof res");
      rchk(OFS_TEMP_RES, 32'hFFFF, "temp res0");
      rchk(OFS_TEMP_RES + 8'hC, 32'hFFFF, "temp res");
      xfer(1'b0, 8'h14, 32'h0);
      chk("slverr", 1, er);
      xfer(1'b1, OFS_WAVE, 32'hC2C7);
      rchk(OFS_WAVE, 32'h0207, "wave mask");
      xfer(1'b1, OFS_WAVE, 32'h0102);
      @(negedge sys_clk);
      chk("hit2 floor", 4, second_stop_wave);
      // partial hit sets, codes 0 to 4: timeout, flag, irq, clear
      for (int c = 0; c < 5; c++)
      begin
         xfer(1'b1, OFS_CTRL, 32'(c) | 32'h8);
         xfer(1'b1, OFS_MASK, 32'h1);
         fork
            i_tdc_model.tof(c, 3);
            run(1'b1, 2'h0, 400);
         join
         chk("window", 1, n >= (BASE << c) + 1 && n <= (BASE << c) + 3);
         // irq is registered from the flag, one cycle behind the abort pulse
         @(negedge sys_clk);
         chk("irq", 1, irq);
         rchk(OFS_STATUS, 32'h1, "status");
         rchk(OFS_TOF_RES + 8'h14, 32'hFFFF, "hit6 res");
         xfer(1'b1, OFS_STATUS, 32'h7);
         repeat (2) @(negedge sys_clk);
         chk("irq clr", 0, irq);
      end
      fork
         i_tdc_model.tof(6, 2);
         run(1'b1, 2'h0, 200);
      join
      chk("no abort", 200, n);
      rchk(OFS_STATUS, 32'h2, "done");
      rchk(OFS_TOF_RES, 32'h1000, "hit1 res");
      xfer(1'b1, OFS_STATUS, 32'h7);
      xfer(1'b1, OFS_MASK, 32'h0);
      xfer(1'b1, OFS_CTRL, 32'h8);
      run(1'b1, 2'h0, 100);
      repeat (2) @(negedge sys_clk);
      chk("masked irq", 0, irq);
      xfer(1'b1, OFS_MASK, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk("unmasked irq", 1, irq);
      xfer(1'b1, OFS_CTRL, 32'h1);
      repeat (2) @(negedge sys_clk);
      chk("irq off", 0, irq);
      xfer(1'b1, OFS_STATUS, 32'h7);
      fork
         i_tdc_model.temp(3, 16'h1234);
         run(1'b0, 2'h2, 100);
      join
      rchk(OFS_TEMP_RES + 8'h8, 32'h1234, "temp val");
      xfer(1'b1, OFS_STATUS, 32'h7);
      run(1'b0, 2'h2, 100);
      rchk(OFS_STATUS, 32'h5, "open probe");
      rchk(OFS_TEMP_RES + 8'h8, 32'hFFFF, "temp open");
      tally_and_finish;
   end
endmodule // tb_tof_timeout
bind tof_timeout tof_timeout_props i_tof_timeout_props (.sys_clk, .reset_n, .psel,
   .penable, .pwrite, .paddr, .pwdata, .pstrb, .pslverr, .first_stop_wave,
   .second_stop_wave, .meas_abort, .irq);
`default_nettype wire
